// >>> rail_window_pkg.sv
// Constants and types for the rail window threshold bank
package rail_window_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] OFS_CH4_CUTOFF     = 8'h55;
	localparam logic [7:0] OFS_CH5_FAST_UNDER = 8'h60;
	localparam logic [7:0] OFS_CH5_FAST_OVER  = 8'h61;
	localparam logic [7:0] OFS_CH5_SLOW_UNDER = 8'h62;
	localparam logic [7:0] OFS_CH5_SLOW_OVER  = 8'h63;
	localparam logic [7:0] OFS_CH5_FAST_DEB   = 8'h64;

	localparam logic [7:0] RST_UNDER_LIMIT = 8'h00;
	localparam logic [7:0] RST_OVER_LIMIT  = 8'hFF;
	localparam logic [7:0] RST_DEBOUNCE    = 8'h00;
	localparam logic [4:0] RST_CUTOFF_RSVD = 5'h00;
	localparam logic [7:0] READ_UNMAPPED   = 8'h00;

	// ****************************************************************
	// Field layout
	// ****************************************************************
	localparam int CUTOFF_MSB    = 2;
	localparam int RSVD_LSB      = 3;
	localparam int OVER_DEB_LSB  = 4;
	localparam int UNDER_DEB_LSB = 0;
	localparam int DEB_W         = 4;

	// ****************************************************************
	// Cutoff codes and filter shifts
	// ****************************************************************
	localparam logic [2:0] CUTOFF_250HZ = 3'h2;
	localparam logic [2:0] CUTOFF_500HZ = 3'h3;
	localparam logic [2:0] CUTOFF_1KHZ  = 3'h4;
	localparam logic [2:0] CUTOFF_2KHZ  = 3'h5;
	localparam logic [2:0] CUTOFF_4KHZ  = 3'h6;
	localparam logic [2:0] RST_CUTOFF   = CUTOFF_1KHZ;

	localparam logic [2:0] SHIFT_250HZ = 3'h6;
	localparam logic [2:0] SHIFT_500HZ = 3'h5;
	localparam logic [2:0] SHIFT_1KHZ  = 3'h4;
	localparam logic [2:0] SHIFT_2KHZ  = 3'h3;
	localparam logic [2:0] SHIFT_4KHZ  = 3'h2;

	// ****************************************************************
	// Threshold scaling, millivolts
	// ****************************************************************
	localparam int MV_W = 13;
	localparam logic [MV_W-1:0] SCALE1_BASE_MV = 13'h00C8;
	localparam logic [MV_W-1:0] SCALE1_STEP_MV = 13'h0005;
	localparam logic [MV_W-1:0] SCALE4_BASE_MV = 13'h0320;
	localparam logic [MV_W-1:0] SCALE4_STEP_MV = 13'h0014;

	// ****************************************************************
	// Debounce timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int DEB_BASE_NS   = 100;
	localparam int DEB_BASE_CYC  =
		(DEB_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] DEB_LAST_CODE = 4'h9;
	localparam int DEB_SAT_EXP = 10;
	localparam int DEB_CNT_W   = 15;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef logic [MV_W-1:0] mv_t;

	typedef struct packed {
		logic fast_over;
		logic fast_under;
		logic slow_over;
		logic slow_under;
	} fault_flags_t;

endpackage : rail_window_pkg

// >>> rail_window_threshold_regs.sv
// Channel 4 cutoff and channel 5 window limit registers with comparators
`timescale 1ns/10ps
module rail_window_threshold_regs (
	input  wire logic                          sys_clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          reg_wr_i,
	input  wire logic                          reg_rd_i,
	input  wire logic [7:0]                    reg_addr_i,
	input  wire logic [7:0]                    reg_wdata_i,
	output logic      [7:0]                    reg_rdata_o,
	output logic                               reg_ack_o,
	input  wire logic                          range_scale_select_i,
	input  wire logic                          ch4_sample_valid_i,
	input  wire logic [7:0]                    ch4_sample_i,
	output logic      [7:0]                    ch4_slow_filtered_o,
	output logic                               ch4_cutoff_invalid_o,
	input  wire rail_window_pkg::mv_t          ch5_fast_mv_i,
	input  wire rail_window_pkg::mv_t          ch5_slow_mv_i,
	output rail_window_pkg::fault_flags_t      ch5_fault_o
);
	import rail_window_pkg::*;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic mv_t code_to_mv(input logic [7:0] code,
	                                   input logic scale4);
		mv_t wide;
		wide = {5'h00, code};
		if (scale4) begin
			code_to_mv = mv_t'(SCALE4_BASE_MV + wide * SCALE4_STEP_MV);
		end else begin
			code_to_mv = mv_t'(SCALE1_BASE_MV + wide * SCALE1_STEP_MV);
		end
	endfunction : code_to_mv

	function automatic logic [DEB_CNT_W-1:0] deb_cycles(input logic [3:0] c);
		logic [DEB_CNT_W-1:0] base;
		base = DEB_CNT_W'(DEB_BASE_CYC);
		if (c > DEB_LAST_CODE) begin
			deb_cycles = base << DEB_SAT_EXP;
		end else begin
			deb_cycles = base << c;
		end
	endfunction : deb_cycles

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [4:0] cutoff_rsvd_q;
	logic [2:0] slow_path_cutoff_select_q;
	logic [7:0] fast_path_under_limit_q;
	logic [7:0] fast_path_over_limit_q;
	logic [7:0] slow_path_under_limit_q;
	logic [7:0] slow_path_over_limit_q;
	logic [7:0] fast_path_debounce_config_q;

	wire logic hit_cutoff = reg_addr_i == OFS_CH4_CUTOFF;
	wire logic hit_fu     = reg_addr_i == OFS_CH5_FAST_UNDER;
	wire logic hit_fo     = reg_addr_i == OFS_CH5_FAST_OVER;
	wire logic hit_su     = reg_addr_i == OFS_CH5_SLOW_UNDER;
	wire logic hit_so     = reg_addr_i == OFS_CH5_SLOW_OVER;
	wire logic hit_deb    = reg_addr_i == OFS_CH5_FAST_DEB;

	// ****************************************************************
	// Write strobes
	// ****************************************************************
	wire logic wr_cutoff = reg_wr_i & hit_cutoff;
	wire logic wr_fu     = reg_wr_i & hit_fu;
	wire logic wr_fo     = reg_wr_i & hit_fo;
	wire logic wr_su     = reg_wr_i & hit_su;
	wire logic wr_so     = reg_wr_i & hit_so;
	wire logic wr_deb    = reg_wr_i & hit_deb;
	wire logic bus_req   = reg_wr_i | reg_rd_i;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cutoff_rsvd_q               <= RST_CUTOFF_RSVD;
			slow_path_cutoff_select_q   <= RST_CUTOFF;
			fast_path_under_limit_q     <= RST_UNDER_LIMIT;
			fast_path_over_limit_q      <= RST_OVER_LIMIT;
			slow_path_under_limit_q     <= RST_UNDER_LIMIT;
			slow_path_over_limit_q      <= RST_OVER_LIMIT;
			fast_path_debounce_config_q <= RST_DEBOUNCE;
		end else begin
			// Reserved bits are kept so they read back as written
			if (wr_cutoff) begin
				cutoff_rsvd_q             <= reg_wdata_i[7:RSVD_LSB];
				slow_path_cutoff_select_q <= reg_wdata_i[CUTOFF_MSB:0];
			end
			if (wr_fu) fast_path_under_limit_q <= reg_wdata_i;
			if (wr_fo) fast_path_over_limit_q <= reg_wdata_i;
			if (wr_su) slow_path_under_limit_q <= reg_wdata_i;
			if (wr_so) slow_path_over_limit_q <= reg_wdata_i;
			if (wr_deb) fast_path_debounce_config_q <= reg_wdata_i;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = READ_UNMAPPED;
		if (hit_cutoff) rd_mux = {cutoff_rsvd_q, slow_path_cutoff_select_q};
		if (hit_fu) rd_mux = fast_path_under_limit_q;
		if (hit_fo) rd_mux = fast_path_over_limit_q;
		if (hit_su) rd_mux = slow_path_under_limit_q;
		if (hit_so) rd_mux = slow_path_over_limit_q;
		if (hit_deb) rd_mux = fast_path_debounce_config_q;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= READ_UNMAPPED;
			reg_ack_o   <= 1'b0;
		end else begin
			reg_ack_o <= bus_req;
			if (reg_rd_i) reg_rdata_o <= rd_mux;
		end
	end

	// ****************************************************************
	// Slow-path low-pass filter, channel 4
	// ****************************************************************
	logic [2:0] cut_shift;
	logic       cut_valid;
	always_comb begin
		cut_valid = 1'b1;
		case (slow_path_cutoff_select_q)
			CUTOFF_250HZ: cut_shift = SHIFT_250HZ;
			CUTOFF_500HZ: cut_shift = SHIFT_500HZ;
			CUTOFF_1KHZ:  cut_shift = SHIFT_1KHZ;
			CUTOFF_2KHZ:  cut_shift = SHIFT_2KHZ;
			CUTOFF_4KHZ:  cut_shift = SHIFT_4KHZ;
			default: begin
				cut_shift = SHIFT_1KHZ;
				cut_valid = 1'b0;
			end
		endcase
	end

	// Invalid codes keep the last good corner rather than a guess
	logic [2:0]  shift_q;
	logic [15:0] acc_q;
	wire logic signed [16:0] filt_diff =
		$signed({1'b0, ch4_sample_i, 8'h00}) - $signed({1'b0, acc_q});
	wire logic signed [16:0] filt_step = filt_diff >>> shift_q;
	wire logic [15:0] acc_d = acc_q + filt_step[15:0];

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q              <= SHIFT_1KHZ;
			acc_q                <= 16'h0000;
			ch4_slow_filtered_o  <= 8'h00;
			ch4_cutoff_invalid_o <= 1'b0;
		end else begin
			if (cut_valid) shift_q <= cut_shift;
			ch4_cutoff_invalid_o <= ~cut_valid;
			if (ch4_sample_valid_i) acc_q <= acc_d;
			ch4_slow_filtered_o <= acc_q[15:8];
		end
	end

	// ****************************************************************
	// Channel 5 window comparators
	// ****************************************************************
	wire mv_t fu_mv = code_to_mv(fast_path_under_limit_q, range_scale_select_i);
	wire mv_t fo_mv = code_to_mv(fast_path_over_limit_q, range_scale_select_i);
	wire mv_t su_mv = code_to_mv(slow_path_under_limit_q, range_scale_select_i);
	wire mv_t so_mv = code_to_mv(slow_path_over_limit_q, range_scale_select_i);

	// Index 0 over, index 1 under on the fast path
	wire logic [1:0] fast_raw = {ch5_fast_mv_i < fu_mv,
	                             ch5_fast_mv_i > fo_mv};
	wire logic [3:0] over_compare_settle_time =
		fast_path_debounce_config_q[OVER_DEB_LSB +: DEB_W];
	wire logic [3:0] under_compare_settle_time =
		fast_path_debounce_config_q[UNDER_DEB_LSB +: DEB_W];
	logic [DEB_CNT_W-1:0] fast_target [2];
	assign fast_target[0] = deb_cycles(over_compare_settle_time);
	assign fast_target[1] = deb_cycles(under_compare_settle_time);

	// ****************************************************************
	// Fast-path debounce, one counter per comparator
	// ****************************************************************
	logic [1:0] fast_flag;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_fast_deb
			logic [DEB_CNT_W-1:0] cnt_q;
			logic                 flag_q;
			wire logic differs = fast_raw[gi] != flag_q;
			wire logic settled = cnt_q + 1'b1 >= fast_target[gi];
			assign fast_flag[gi] = flag_q;
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					cnt_q  <= '0;
					flag_q <= 1'b0;
				end else if (!differs) begin
					cnt_q <= '0;
				end else if (settled) begin
					cnt_q  <= '0;
					flag_q <= fast_raw[gi];
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Fault outputs
	// ****************************************************************
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ch5_fault_o <= '0;
		end else begin
			ch5_fault_o.fast_over  <= fast_flag[0];
			ch5_fault_o.fast_under <= fast_flag[1];
			ch5_fault_o.slow_over  <= ch5_slow_mv_i > so_mv;
			ch5_fault_o.slow_under <= ch5_slow_mv_i < su_mv;
		end
	end

endmodule : rail_window_threshold_regs

// >>> rail_window_checker.sv
// Port assertions for the rail window threshold bank
`timescale 1ns/10ps
module rail_window_checker
	import rail_window_pkg::*;
(
	input wire logic                          sys_clk_i,
	input wire logic                          rst_n_i,
	input wire logic                          reg_wr_i,
	input wire logic                          reg_rd_i,
	input wire logic [7:0]                    reg_addr_i,
	input wire logic [7:0]                    reg_wdata_i,
	input wire logic [7:0]                    reg_rdata_o,
	input wire logic                          reg_ack_o,
	input wire logic                          range_scale_select_i,
	input wire logic                          ch4_cutoff_invalid_o,
	input wire rail_window_pkg::mv_t          ch5_fast_mv_i,
	input wire rail_window_pkg::mv_t          ch5_slow_mv_i,
	input wire rail_window_pkg::fault_flags_t ch5_fault_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ****************************************************************
	// Shadow limits and expected compares
	// ****************************************************************
	logic [7:0] fast_over_q;
	logic [7:0] slow_under_q;
	logic [7:0] slow_over_q;
	wire mv_t base_mv = range_scale_select_i ? 13'h0320 : 13'h00C8;
	wire mv_t step_mv = range_scale_select_i ? 13'h0014 : 13'h0005;
	wire fast_hi = ch5_fast_mv_i > base_mv + step_mv * mv_t'(fast_over_q);
	wire slow_hi = ch5_slow_mv_i > base_mv + step_mv * mv_t'(slow_over_q);
	wire slow_lo = ch5_slow_mv_i < base_mv + step_mv * mv_t'(slow_under_q);
	wire [2:0] cut_code = reg_wdata_i[2:0];
	wire cut_wr = reg_wr_i && reg_addr_i == 8'h55;
	wire cut_bad = cut_code < 3'h2 || cut_code == 3'h7;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fast_over_q  <= 8'hFF;
			slow_under_q <= 8'h00;
			slow_over_q  <= 8'hFF;
		end else if (reg_wr_i) begin
			fast_over_q  <= reg_addr_i == 8'h61 ? reg_wdata_i : fast_over_q;
			slow_under_q <= reg_addr_i == 8'h62 ? reg_wdata_i : slow_under_q;
			slow_over_q  <= reg_addr_i == 8'h63 ? reg_wdata_i : slow_over_q;
		end
	end
	a_ack_after_req: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
		else $error("no ack after request");
	a_ack_has_cause: assert property (reg_ack_o |-> $past(reg_wr_i || reg_rd_i))
		else $error("ack without request");
	a_rdata_held: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
		else $error("read data moved");
	a_cutoff_bad_flag: assert property (cut_wr && cut_bad |-> ##2 ch4_cutoff_invalid_o)
		else $error("bad cutoff not flagged");
	a_cutoff_good_flag: assert property (cut_wr && !cut_bad |-> ##2 !ch4_cutoff_invalid_o)
		else $error("good cutoff flagged");
	a_slow_over_flag: assert property (slow_hi |=> ch5_fault_o.slow_over)
		else $error("slow over missed");
	a_slow_under_clear: assert property (!slow_lo |=> !ch5_fault_o.slow_under)
		else $error("slow under false");
	a_fast_over_settled: assert property ($rose(ch5_fault_o.fast_over) |->
		$past(fast_hi, 2) && $past(fast_hi, 10))
		else $error("fast over too early");
	c_fast_rise: cover property ($rose(ch5_fault_o.fast_over));
	c_bad_cutoff: cover property (cut_wr && cut_bad);
	c_slow_under: cover property ($rose(ch5_fault_o.slow_under));
endmodule : rail_window_checker

// >>> rail_host_model.sv
// Management host model issuing single register reads and writes
`timescale 1ns/10ps
module rail_host_model (
	input  wire logic       sys_clk_i,
	input  wire logic       reg_ack_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o
);
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end
	// One request pulse, then a bounded wait for the ack
	task automatic access(input logic wr, input logic [7:0] addr,
		input logic [7:0] data, output logic [7:0] rdata, output logic ok);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		reg_wr_o <= wr;
		reg_rd_o <= !wr;
		reg_addr_o <= addr;
		reg_wdata_o <= data;
		@(posedge sys_clk_i);
		reg_wr_o <= 1'b0;
		reg_rd_o <= 1'b0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (reg_ack_i !== 1'b1 && n < 8);
		rdata = reg_rdata_i;
		ok = reg_ack_i === 1'b1;
	endtask : access
endmodule : rail_host_model

// >>> test_rail_window_threshold_regs.sv
// Self-checking bench for the rail window threshold bank
`timescale 1ns/10ps
module test_rail_window_threshold_regs;
	import rail_window_pkg::*;
	logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, reg_ack_o, ok;
	logic range_scale_select_i, ch4_sample_valid_i, ch4_cutoff_invalid_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
	logic [7:0] ch4_sample_i, ch4_slow_filtered_o;
	mv_t ch5_fast_mv_i, ch5_slow_mv_i;
	fault_flags_t ch5_fault_o;
	int err_count, compares, lo, hi;
	logic [7:0] ofs [6] = '{8'h55, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64};
	logic [7:0] rst_v [6] = '{8'h04, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00};
	rail_window_threshold_regs rail_window_threshold_regs_inst (
		.sys_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .reg_ack_o, .range_scale_select_i, .ch4_sample_valid_i,
		.ch4_sample_i, .ch4_slow_filtered_o, .ch4_cutoff_invalid_o,
		.ch5_fast_mv_i, .ch5_slow_mv_i, .ch5_fault_o);
	rail_host_model rail_host_model_inst (
		.sys_clk_i, .reg_ack_i(reg_ack_o), .reg_rdata_i(reg_rdata_o),
		.reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i));
	always #5 sys_clk_i = ~sys_clk_i;
	// ****************************************************************
	// Access and compare tasks
	// ****************************************************************
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask : chk_bit
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		rail_host_model_inst.access(1'b1, a, d, rd, ok);
		chk_bit(ok, 1'b1);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		rail_host_model_inst.access(1'b0, a, 8'h00, rd, ok);
		chk_byte(rd, exp);
	endtask : rd_chk
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : settle
	// Glitch, then a settled rise and fall of the fast over flag
	task automatic deb(input logic [3:0] code, input int n);
		wr(8'h64, {code, 4'hF});
		@(posedge sys_clk_i);
		ch5_fast_mv_i <= 13'h012D;
		repeat (n - 3) @(posedge sys_clk_i);
		ch5_fast_mv_i <= 13'h00FA;
		#1;
		chk_bit(ch5_fault_o.fast_over, 1'b0);
		@(posedge sys_clk_i);
		ch5_fast_mv_i <= 13'h012D;
		settle(n - 2);
		chk_bit(ch5_fault_o.fast_over, 1'b0);
		settle(4);
		chk_bit(ch5_fault_o.fast_over, 1'b1);
		@(posedge sys_clk_i);
		ch5_fast_mv_i <= 13'h00FA;
		settle(n + 3);
		chk_bit(ch5_fault_o.fast_over, 1'b0);
	endtask : deb
	task tally_and_finish;
		if (err_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	initial begin
		#800000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		sys_clk_i = 1'b0;
		rst_n_i = 1'b0;
		range_scale_select_i = 1'b0;
		ch4_sample_valid_i = 1'b1;
		ch4_sample_i = 8'h80;
		ch5_fast_mv_i = 13'h00FA;
		ch5_slow_mv_i = 13'h00FA;
		err_count = 0;
		compares = 0;
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		foreach (ofs[i])
			rd_chk(ofs[i], rst_v[i]);
		rd_chk(8'h56, 8'h00);
		chk_byte({4'h0, ch5_fault_o}, 8'h00);
		foreach (ofs[i])
			wr(ofs[i], 8'hA8 + 8'(i));
		foreach (ofs[i])
			rd_chk(ofs[i], 8'hA8 + 8'(i));
		for (int c = 0; c < 8; c++) begin
			wr(8'h55, {5'h1F, 3'(c)});
			settle(2);
			chk_bit(ch4_cutoff_invalid_o, c < 2 || c == 7);
		end
		chk_bit(ch4_slow_filtered_o inside {8'h7F, 8'h80}, 1'b1);
		for (int s = 0; s < 2; s++) begin
			@(posedge sys_clk_i);
			range_scale_select_i <= s[0];
			wr(8'h62, 8'h64);
			wr(8'h63, 8'h96);
			lo = s ? 800 + 20 * 100 : 200 + 5 * 100;
			hi = s ? 800 + 20 * 150 : 200 + 5 * 150;
			for (int k = 0; k < 4; k++) begin
				@(posedge sys_clk_i);
				ch5_slow_mv_i <= mv_t'(k < 2 ? lo - 1 + k : hi - 2 + k);
				settle(2);
				chk_bit(ch5_fault_o.slow_under, k == 0);
				chk_bit(ch5_fault_o.slow_over, k == 3);
			end
		end
		@(posedge sys_clk_i);
		range_scale_select_i <= 1'b0;
		wr(8'h61, 8'h14);
		deb(4'h2, 40);
		deb(4'h9, 5120);
		deb(4'hF, 10240);
		chk_bit(ch5_fault_o.fast_under, 1'b1);
		wr(8'h64, 8'hF2);
		wr(8'h60, 8'h00);
		settle(37);
		chk_bit(ch5_fault_o.fast_under, 1'b1);
		settle(4);
		chk_bit(ch5_fault_o.fast_under, 1'b0);
		tally_and_finish();
	end
endmodule : test_rail_window_threshold_regs
bind rail_window_threshold_regs rail_window_checker rail_window_checker_inst (
	.sys_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
	.reg_rdata_o, .reg_ack_o, .range_scale_select_i, .ch4_cutoff_invalid_o,
	.ch5_fast_mv_i, .ch5_slow_mv_i, .ch5_fault_o);
